/* File: cfg_event_pkg.sv */
package cfg_event_pkg;
	// Register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_EVENTS = 8;

	// Register byte offsets, one aligned word each
	localparam logic [7:0] OFF_SET_CHOICE = 8'h00;
	localparam logic [7:0] OFF_RESTORE_CMD = 8'h04;
	localparam logic [7:0] OFF_STORE_CMD = 8'h08;
	localparam logic [7:0] OFF_POWERUP = 8'h0c;
	localparam logic [7:0] OFF_ACTIVE_REPORT = 8'h10;
	localparam logic [7:0] OFF_EVENT_CHOICE = 8'h14;
	localparam logic [7:0] OFF_NOTIFY = 8'h18;
	localparam logic [7:0] OFF_HOST_PORT = 8'h1c;

	// Configuration set codes
	localparam logic [1:0] SET_FACTORY = 2'h0;
	localparam logic [1:0] SET_USER0 = 2'h1;
	localparam logic [1:0] SET_USER1 = 2'h2;
	localparam logic [2:0] REPORT_MAX = 3'h4;

	// Reset values
	localparam logic [1:0] SET_CHOICE_RST = 2'h0;
	localparam logic [1:0] POWERUP_RST = 2'h0;
	localparam logic [2:0] REPORT_RST = 3'h0;
	localparam logic [2:0] EV_CHOICE_RST = 3'h0;
	localparam logic [7:0] NOTIFY_RST = 8'h00;
	localparam logic [15:0] HOST_PORT_RST = 16'h0000;

	// Event bit positions and their message codes
	localparam int EV_BEGIN = 0;
	localparam int EV_FINISH = 1;
	localparam int EV_IMAGE_OVR = 2;
	localparam int EV_NOTICE_OVR = 3;
	localparam int EV_IN1 = 4;
	localparam int EV_IN2 = 5;
	localparam int EV_OUTPUT_LINE_ONE_EDGE = 6;
	localparam int EV_OUTPUT_LINE_TWO_EDGE = 7;
	localparam logic [15:0] EV_CODE [NUM_EVENTS] = '{16'h9105, 16'h9106, 16'h9107, 16'h9108,
		16'h9101, 16'h9102, 16'h9103, 16'h9104};

	// Control sequencer states
	typedef enum logic {boot_s, idle_s} ctl_state_e;
endpackage

/* File: line_edge.sv */
`timescale 1ns/1ps
module line_edge #(
	parameter bit SYNC = 1'b1
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic line,
	output logic rise
);
	generate
		if (SYNC) begin : g_sync
			logic s1_reg, s2_reg, s3_reg, stable_reg;
			// Three stages; the level counts only once stages two and three agree
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					stable_reg <= 1'b0;
				end else begin
					s1_reg <= line;
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) stable_reg <= s3_reg;
				end
			end
			assign rise = s2_reg && s3_reg && !stable_reg;
			input_rise_a: assert property (@(posedge clock) disable iff (!rst_n)
				rise |=> stable_reg && !rise)
				else $error("input edge not single pulse");
		end else begin : g_local
			logic prev_reg;
			// Same-clock line, plain edge detect
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) prev_reg <= 1'b0;
				else prev_reg <= line;
			end
			assign rise = line && !prev_reg;
			output_rise_a: assert property (@(posedge clock) disable iff (!rst_n)
				rise |-> line && !$past(line))
				else $error("output edge without rising level");
		end
	endgenerate
endmodule

/* File: config_store.sv */
`timescale 1ns/1ps
module config_store import cfg_event_pkg::*; #(
	parameter int SET_W = 32,
	parameter logic [SET_W-1:0] FACTORY_SET = '0
) (
	input wire logic clock,
	input wire logic nv_rst_n,
	input wire logic [1:0] rd_sel,
	output logic [SET_W-1:0] rd_data,
	input wire logic wr_en,
	input wire logic [1:0] wr_sel,
	input wire logic [SET_W-1:0] wr_data,
	input wire logic pdef_wr,
	input wire logic [1:0] pdef_data,
	output logic [1:0] pdef
);
	logic [SET_W-1:0] user_set_reg [2];
	logic [1:0] pdef_reg;

	// Retained contents; only the storage's own clear touches them, not device reset
	// Erased user sets read zero until saved, so an unsaved set differs from a non-zero factory set
	always_ff @(posedge clock or negedge nv_rst_n) begin
		if (!nv_rst_n) begin
			user_set_reg[0] <= '0;
			user_set_reg[1] <= '0;
			pdef_reg <= POWERUP_RST;
		end else begin
			if (wr_en && wr_sel == SET_USER0) user_set_reg[0] <= wr_data;
			if (wr_en && wr_sel == SET_USER1) user_set_reg[1] <= wr_data;
			if (pdef_wr) pdef_reg <= pdef_data;
		end
	end

	// Factory set is fixed and cannot be overwritten
	assign rd_data = (rd_sel == SET_USER0) ? user_set_reg[0] :
		(rd_sel == SET_USER1) ? user_set_reg[1] : FACTORY_SET;
	assign pdef = pdef_reg;

	store_user_a: assert property (@(posedge clock) disable iff (!nv_rst_n)
		wr_en && wr_sel != SET_FACTORY |=> rd_sel != $past(wr_sel) || rd_data == $past(wr_data))
		else $error("saved set not readable");
	factory_fixed_a: assert property (@(posedge clock) disable iff (!nv_rst_n)
		rd_sel == SET_FACTORY |-> rd_data == FACTORY_SET)
		else $error("factory set altered");
endmodule

/* File: cfg_event_ctl.sv */
`timescale 1ns/1ps
// Functional notes
// - Set selector takes 0 factory, 1 user zero, 2 user one; targets load and save.
// - Factory set has fixed factory contents; loading it restores the original setup.
// - Load command copies selected stored set into live settings, effective at once.
// - Save command stores live settings under selected set; write-only, reads zero.
// - After reset the power-up default set is loaded; default field is RW, codes 0-2.
// - Read-only report shows the set loaded since reset; 0 factory, 1-2 user sets.
// - Event codes 0x9105-0x9108 for capture and overruns, 0x9101-0x9104 for lines.
// - Enabled event sends a message per occurrence, repeats while still pending merge into one; disabled event sends nothing.
// - Capture start raises the capture-begin event.
// - Capture completion raises the capture-finish event.
// - Image stream FIFO overflow raises the image overrun event.
// - Message FIFO overflow raises the notice overrun event.
// - Rising edge on input line one or two raises its input event.
// - Rising edge on output line one or two raises its output event.
// - Messages enter the output stage only while channel is open; host port zero closes it.
module cfg_event_ctl import cfg_event_pkg::*; #(
	parameter int SET_W = 32,
	parameter logic [SET_W-1:0] FACTORY_SET = '0
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic nv_rst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_wdata,
	output logic [DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	output logic [SET_W-1:0] live_settings,
	output logic settings_apply,
	input wire logic capture_begin,
	input wire logic capture_finish,
	input wire logic image_fifo_overrun,
	input wire logic notice_fifo_overrun,
	input wire logic general_input_one,
	input wire logic general_input_two,
	input wire logic general_output_one,
	input wire logic general_output_two,
	output logic event_msg_valid,
	input wire logic event_msg_ready,
	output logic [15:0] event_msg_code
);
	ctl_state_e state_reg, state_next;
	logic [1:0] set_choice_reg, set_choice_next;
	logic [2:0] report_reg, report_next;
	logic [SET_W-1:0] live_reg, live_next;
	logic apply_reg, apply_next;
	logic [2:0] ev_choice_reg, ev_choice_next;
	logic [NUM_EVENTS-1:0] notify_reg, notify_next;
	logic [15:0] host_port_reg, host_port_next;
	logic [NUM_EVENTS-1:0] pending_reg, pending_next;
	logic msg_valid_reg, msg_valid_next;
	logic [15:0] msg_code_reg, msg_code_next;
	logic [DATA_W-1:0] rdata_reg;
	logic rvalid_reg;

	// Address decode
	wire hit_set_choice = reg_addr == OFF_SET_CHOICE;
	wire hit_restore = reg_addr == OFF_RESTORE_CMD;
	wire hit_store = reg_addr == OFF_STORE_CMD;
	wire hit_powerup = reg_addr == OFF_POWERUP;
	wire hit_report = reg_addr == OFF_ACTIVE_REPORT;
	wire hit_ev_choice = reg_addr == OFF_EVENT_CHOICE;
	wire hit_notify = reg_addr == OFF_NOTIFY;
	wire hit_host_port = reg_addr == OFF_HOST_PORT;

	// Set codes above the user sets are refused, so the field never holds a dead code
	wire set_code_ok = reg_wdata <= DATA_W'(SET_USER1);
	wire booting = state_reg == boot_s;

	// Commands act only once the power-up load is done; during it they are dropped
	wire restore_fire = !booting && reg_wr && hit_restore;
	wire store_fire = !booting && reg_wr && hit_store;
	wire pdef_wr = reg_wr && hit_powerup && set_code_ok;

	// Translate a written event code into its table index
	function automatic logic [3:0] code_lookup(input logic [DATA_W-1:0] code);
		logic [3:0] res;
		res = 4'h0;
		for (int i = 0; i < NUM_EVENTS; i++) begin
			if (code == DATA_W'(EV_CODE[i])) res = {1'b1, 3'(i)};
		end
		return res;
	endfunction

	// Lowest pending event index wins when several wait
	function automatic logic [2:0] first_set(input logic [NUM_EVENTS-1:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = NUM_EVENTS - 1; i >= 0; i--) begin
			if (v[i]) idx = 3'(i);
		end
		return idx;
	endfunction

	// Decoded selector write; the top bit says the code is in the table
	wire [3:0] ev_lookup = code_lookup(reg_wdata);
	wire ev_code_ok = ev_lookup[3];

	// Stored-set access: during boot the power-up default picks the set
	logic [1:0] pdef;
	logic [SET_W-1:0] nv_rd_data;
	wire [1:0] nv_rd_sel = booting ? pdef : set_choice_reg;

	config_store #(
		.SET_W(SET_W),
		.FACTORY_SET(FACTORY_SET)
	) u_store (
		.clock(clock),
		.nv_rst_n(nv_rst_n),
		.rd_sel(nv_rd_sel),
		.rd_data(nv_rd_data),
		.wr_en(store_fire),
		.wr_sel(set_choice_reg),
		.wr_data(live_reg),
		.pdef_wr(pdef_wr),
		.pdef_data(reg_wdata[1:0]),
		.pdef(pdef)
	);

	// Sequencer: one boot cycle that loads the default, then idle for good
	assign state_next = idle_s;

	// Live settings and the loaded-set report follow boot or restore
	assign live_next = (booting || restore_fire) ? nv_rd_data : live_reg;
	assign apply_next = booting || restore_fire;
	assign report_next = booting ? {1'b0, pdef} :
		restore_fire ? {1'b0, set_choice_reg} : report_reg;
	assign set_choice_next = (reg_wr && hit_set_choice && set_code_ok) ? reg_wdata[1:0] : set_choice_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= boot_s;
			set_choice_reg <= SET_CHOICE_RST;
			report_reg <= REPORT_RST;
			live_reg <= FACTORY_SET;
			apply_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			set_choice_reg <= set_choice_next;
			report_reg <= report_next;
			live_reg <= live_next;
			apply_reg <= apply_next;
		end
	end

	// Event selector, per-event enables and the channel port
	assign ev_choice_next = (reg_wr && hit_ev_choice && ev_code_ok) ? ev_lookup[2:0] : ev_choice_reg;
	wire notify_wr = reg_wr && hit_notify;
	wire [NUM_EVENTS-1:0] notify_sel = 8'h01 << ev_choice_reg;
	assign notify_next = notify_wr ? ((notify_reg & ~notify_sel) | (reg_wdata[0] ? notify_sel : 8'h00))
		: notify_reg;
	assign host_port_next = (reg_wr && hit_host_port) ? reg_wdata[15:0] : host_port_reg;
	// A zero port closes the channel; queued events wait there until it reopens
	wire chan_open = host_port_reg != 16'h0000;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ev_choice_reg <= EV_CHOICE_RST;
			notify_reg <= NOTIFY_RST;
			host_port_reg <= HOST_PORT_RST;
		end else begin
			ev_choice_reg <= ev_choice_next;
			notify_reg <= notify_next;
			host_port_reg <= host_port_next;
		end
	end

	// Line edge detectors: pins get the full synchroniser, own outputs do not
	logic in1_rise, in2_rise, output_line_one_edge_rise, output_line_two_edge_rise;

	line_edge #(.SYNC(1'b1)) u_in1 (
		.clock(clock),
		.rst_n(rst_n),
		.line(general_input_one),
		.rise(in1_rise)
	);

	line_edge #(.SYNC(1'b1)) u_in2 (
		.clock(clock),
		.rst_n(rst_n),
		.line(general_input_two),
		.rise(in2_rise)
	);

	line_edge #(.SYNC(1'b0)) u_output_line_one_edge (
		.clock(clock),
		.rst_n(rst_n),
		.line(general_output_one),
		.rise(output_line_one_edge_rise)
	);

	line_edge #(.SYNC(1'b0)) u_output_line_two_edge (
		.clock(clock),
		.rst_n(rst_n),
		.line(general_output_two),
		.rise(output_line_two_edge_rise)
	);

	// Raw event vector in table order
	wire [NUM_EVENTS-1:0] raw_events = {output_line_two_edge_rise, output_line_one_edge_rise, in2_rise, in1_rise,
		notice_fifo_overrun,
		image_fifo_overrun,
		capture_finish,
		capture_begin};

	// Only enabled events on an open channel are queued
	wire [NUM_EVENTS-1:0] event_set = raw_events & notify_reg & {NUM_EVENTS{chan_open}};

	// Output stage: refill when empty or when the host takes the current message
	wire stage_free = !msg_valid_reg || event_msg_ready;
	wire msg_load = stage_free && chan_open && (pending_reg != 8'h00);
	wire [2:0] pick_idx = first_set(pending_reg);
	wire [NUM_EVENTS-1:0] pick_mask = msg_load ? (8'h01 << pick_idx) : 8'h00;

	// A new occurrence in the cycle its bit is served stays pending: set beats clear
	assign pending_next = (pending_reg & ~pick_mask) | event_set;
	assign msg_valid_next = msg_load || (msg_valid_reg && !event_msg_ready);
	assign msg_code_next = msg_load ? EV_CODE[pick_idx] : msg_code_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pending_reg <= 8'h00;
			msg_valid_reg <= 1'b0;
			msg_code_reg <= 16'h0000;
		end else begin
			pending_reg <= pending_next;
			msg_valid_reg <= msg_valid_next;
			msg_code_reg <= msg_code_next;
		end
	end

	// Read mux; commands are write-only and read as zero
	wire [DATA_W-1:0] rd_word =
		hit_set_choice ? DATA_W'(set_choice_reg) :
		hit_powerup ? DATA_W'(pdef) :
		hit_report ? DATA_W'(report_reg) :
		hit_ev_choice ? DATA_W'(EV_CODE[ev_choice_reg]) :
		hit_notify ? DATA_W'(notify_reg[ev_choice_reg]) :
		hit_host_port ? DATA_W'(host_port_reg) : 32'h0000_0000;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0000_0000;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg <= reg_rd ? rd_word : rdata_reg;
			rvalid_reg <= reg_rd;
		end
	end

	// Registered values straight to the ports
	assign reg_rdata = rdata_reg;
	assign reg_rvalid = rvalid_reg;
	assign live_settings = live_reg;
	assign settings_apply = apply_reg;
	assign event_msg_valid = msg_valid_reg;
	assign event_msg_code = msg_code_reg;

	// Checks
	selector_legal_a: assert property (@(posedge clock) disable iff (!rst_n)
		set_choice_reg <= SET_USER1)
		else $error("set selector out of range");
	powerup_load_a: assert property (@(posedge clock) disable iff (!rst_n)
		booting |=> apply_reg && report_reg == {1'b0, $past(pdef)} && live_reg == $past(nv_rd_data))
		else $error("power-up default not loaded");
	restore_cmd_a: assert property (@(posedge clock) disable iff (!rst_n)
		restore_fire |=> settings_apply && live_settings == $past(nv_rd_data)
			&& report_reg == {1'b0, $past(set_choice_reg)})
		else $error("restore did not apply selected set");
	report_range_a: assert property (@(posedge clock) disable iff (!rst_n)
		report_reg <= REPORT_MAX && (apply_reg || $stable(report_reg)))
		else $error("loaded-set report wrong");
	store_read_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
		reg_rd && hit_store |=> reg_rvalid && reg_rdata == 32'h0000_0000)
		else $error("save command read back data");
	notify_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		notify_wr |=> notify_reg[$past(ev_choice_reg)] == $past(reg_wdata[0]))
		else $error("enable not stored for selected event");
	event_queued_a: assert property (@(posedge clock) disable iff (!rst_n)
		event_set != 8'h00 |=> pending_reg != 8'h00 || msg_valid_reg)
		else $error("enabled event lost");
	silent_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		notify_reg == 8'h00 && pending_reg == 8'h00 && !msg_valid_reg |=> !msg_valid_reg)
		else $error("message for disabled event");
	closed_channel_a: assert property (@(posedge clock) disable iff (!rst_n)
		!chan_open && !msg_valid_reg |=> !msg_valid_reg)
		else $error("message issued on closed channel");
	code_legal_a: assert property (@(posedge clock) disable iff (!rst_n)
		msg_valid_reg |-> msg_code_reg >= 16'h9101 && msg_code_reg <= 16'h9108)
		else $error("illegal event code");
	msg_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		msg_valid_reg && !event_msg_ready |=> msg_valid_reg && $stable(msg_code_reg))
		else $error("message dropped before taken");

	// Refused writes leave the field as it was
	selector_refuse_a: assert property (@(posedge clock) disable iff (!rst_n)
		reg_wr && hit_set_choice && !set_code_ok |=> $stable(set_choice_reg))
		else $error("illegal set code accepted");
	powerup_refuse_a: assert property (@(posedge clock) disable iff (!rst_n)
		reg_wr && hit_powerup && !set_code_ok |=> $stable(pdef))
		else $error("illegal power-up code accepted");
	event_refuse_a: assert property (@(posedge clock) disable iff (!rst_n)
		reg_wr && hit_ev_choice && !ev_code_ok |=> $stable(ev_choice_reg))
		else $error("unknown event code accepted");

	// Accepted writes land in the addressed field
	powerup_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		pdef_wr |=> pdef == $past(reg_wdata[1:0]))
		else $error("power-up default not stored");
	event_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		reg_wr && hit_ev_choice && ev_code_ok |=> EV_CODE[ev_choice_reg] == $past(reg_wdata[15:0]))
		else $error("event selector not stored");
	port_write_a: assert property (@(posedge clock) disable iff (!rst_n)
		reg_wr && hit_host_port |=> host_port_reg == $past(reg_wdata[15:0]))
		else $error("host port not stored");

	// Commands: a save never reloads, a load pulses apply once
	store_no_apply_a: assert property (@(posedge clock) disable iff (!rst_n)
		store_fire |=> !settings_apply)
		else $error("save command reloaded settings");
	apply_single_a: assert property (@(posedge clock) disable iff (!rst_n)
		settings_apply && !restore_fire |=> !settings_apply)
		else $error("apply pulse too long");

	// Event gating and service of the pending bits
	disabled_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
		(raw_events & notify_reg) == 8'h00 && pending_reg == 8'h00 |=> pending_reg == 8'h00)
		else $error("disabled event queued");
	closed_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
		!chan_open && pending_reg == 8'h00 |=> pending_reg == 8'h00)
		else $error("event queued on closed channel");
	served_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		msg_load && !event_set[pick_idx] |=> !pending_reg[$past(pick_idx)])
		else $error("served event still pending");

	// Read data follows the field as it stood at the strobe
	report_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		reg_rd && hit_report |=> reg_rvalid && reg_rdata == DATA_W'($past(report_reg)))
		else $error("loaded-set report misread");
	notify_read_a: assert property (@(posedge clock) disable iff (!rst_n)
		reg_rd && hit_notify |=> reg_rvalid && reg_rdata == DATA_W'($past(notify_reg[ev_choice_reg])))
		else $error("enable misread for selected event");
endmodule

/* File: host_app_model.sv */
`timescale 1ns/1ps
// Host end of the event message channel; stall holds ready low to play a slow host
module host_app_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic event_msg_valid,
	input wire logic [15:0] event_msg_code,
	output logic event_msg_ready,
	output logic [15:0] got_code,
	output logic [31:0] got_cnt
);
	// Ready follows stall at once, so a slow host is simply a long ready-low stretch
	assign event_msg_ready = ~stall;
	// A message is taken only at the edge where valid and ready meet
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			got_code <= 16'h0000;
			got_cnt <= 32'h0000_0000;
		end else if (event_msg_valid && event_msg_ready) begin
			got_code <= event_msg_code;
			got_cnt <= got_cnt + 32'h0000_0001;
		end
	end
endmodule

/* File: user_set_and_event_control_test.sv */
`timescale 1ns/1ps
module user_set_and_event_control_test import cfg_event_pkg::*;;
	localparam logic [31:0] FSET = 32'hc3c3_5a5a;
	localparam logic [31:0] ZERO = 32'h0000_0000;
	localparam logic [31:0] ONE = 32'h0000_0001;
	localparam logic [31:0] TWO = 32'h0000_0002;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic nv_rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [31:0] reg_rdata, live_settings, got_cnt, cnt0;
	logic reg_rvalid, settings_apply, event_msg_valid, event_msg_ready;
	logic [15:0] event_msg_code, got_code;
	logic [7:0] src = 8'h00;
	logic stall = 1'b0;
	int error_cnt = 0;
	int num_checks = 0;

	// 10 MHz system clock
	always #50 clock = ~clock;

	// A non-zero factory word so a load that misses the factory contents shows up
	cfg_event_ctl #(.SET_W(32), .FACTORY_SET(FSET)) uut (.clock(clock), .rst_n(rst_n), .nv_rst_n(nv_rst_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .live_settings(live_settings), .settings_apply(settings_apply),
		.capture_begin(src[0]), .capture_finish(src[1]), .image_fifo_overrun(src[2]),
		.notice_fifo_overrun(src[3]), .general_input_one(src[4]), .general_input_two(src[5]),
		.general_output_one(src[6]), .general_output_two(src[7]), .event_msg_valid(event_msg_valid),
		.event_msg_ready(event_msg_ready), .event_msg_code(event_msg_code));

	host_app_model host (.clock(clock), .rst_n(rst_n), .stall(stall), .event_msg_valid(event_msg_valid),
		.event_msg_code(event_msg_code), .event_msg_ready(event_msg_ready), .got_code(got_code),
		.got_cnt(got_cnt));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task print_verdict;
		$display("Checks %0d, errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Write strobe lasts one cycle; returns just after the taking edge has settled
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask

	// Read data only counts when rvalid stands in the cycle after the strobe
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		check((reg_rvalid === 1'b1) ? reg_rdata : 32'hdead_beef, exp);
	endtask

	// Pin lines stay up three cycles so two synchroniser stages agree; other sources pulse once
	task pulse(input logic [7:0] m);
		@(posedge clock);
		src <= m;
		@(posedge clock);
		src <= m & 8'h30;
		repeat (2) @(posedge clock);
		src <= 8'h00;
	endtask

	// Count n is taken before the stimulus; pin lines add synchroniser cycles to the wait
	task expect_msg(input logic [15:0] code, input logic [31:0] n);
		for (int k = 0; k < 20 && got_cnt == n; k++) begin
			@(posedge clock);
			#1;
		end
		if (got_cnt == n) begin
			error_cnt++;
			$display("Error at %0t: no event message", $time);
			print_verdict();
		end else begin
			check(32'(got_code), 32'(code));
		end
	endtask

	task quiet;
		logic [31:0] n;
		n = got_cnt;
		repeat (12) @(posedge clock);
		#1;
		check(got_cnt, n);
	endtask

	task do_reset(input logic nv);
		@(posedge clock);
		rst_n <= 1'b0;
		if (nv) begin
			nv_rst_n <= 1'b0;
		end
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		nv_rst_n <= 1'b1;
		@(posedge clock);
		#1;
	endtask

	task t_boot(input logic [31:0] code);
		check(32'(settings_apply), ONE);
		check(live_settings, FSET);
		@(posedge clock);
		#1;
		check(32'(settings_apply), ZERO);
		rd_chk(OFF_ACTIVE_REPORT, code);
		rd_chk(OFF_POWERUP, code);
		rd_chk(OFF_SET_CHOICE, ZERO);
	endtask

	task t_regs;
		rd_chk(OFF_EVENT_CHOICE, 32'h0000_9105);
		rd_chk(OFF_NOTIFY, ZERO);
		rd_chk(OFF_HOST_PORT, ZERO);
		rd_chk(8'h20, ZERO);
	endtask

	task t_sets;
		wr(OFF_SET_CHOICE, 32'h0000_0003);
		rd_chk(OFF_SET_CHOICE, ZERO);
		wr(OFF_SET_CHOICE, ONE);
		rd_chk(OFF_SET_CHOICE, ONE);
		wr(OFF_STORE_CMD, ZERO);
		check(32'(settings_apply), ZERO);
		rd_chk(OFF_STORE_CMD, ZERO);
		wr(OFF_SET_CHOICE, TWO);
		wr(OFF_RESTORE_CMD, ZERO);
		check(32'(settings_apply), ONE);
		check(live_settings, ZERO);
		rd_chk(OFF_ACTIVE_REPORT, TWO);
		wr(OFF_SET_CHOICE, ONE);
		wr(OFF_RESTORE_CMD, ZERO);
		check(live_settings, FSET);
		rd_chk(OFF_ACTIVE_REPORT, ONE);
		wr(OFF_POWERUP, ONE);
		wr(OFF_POWERUP, 32'h0000_0003);
		rd_chk(OFF_POWERUP, ONE);
		do_reset(1'b0);
		t_boot(ONE);
	endtask

	task t_events;
		for (int i = 0; i < NUM_EVENTS; i++) begin
			wr(OFF_EVENT_CHOICE, 32'(EV_CODE[i]));
			wr(OFF_NOTIFY, ONE);
			rd_chk(OFF_EVENT_CHOICE, 32'(EV_CODE[i]));
		end
		wr(OFF_EVENT_CHOICE, 32'h0000_9100);
		rd_chk(OFF_EVENT_CHOICE, 32'h0000_9104);
		wr(OFF_HOST_PORT, 32'h0000_1234);
		for (int i = 0; i < NUM_EVENTS; i++) begin
			cnt0 = got_cnt;
			pulse(8'(1 << i));
			expect_msg(EV_CODE[i], cnt0);
		end
		// All sources at once against a stalled host, plus a repeat that must merge
		@(posedge clock);
		stall <= 1'b1;
		pulse(8'hff);
		pulse(8'h02);
		repeat (8) @(posedge clock);
		stall <= 1'b0;
		for (int i = 0; i < NUM_EVENTS; i++) begin
			expect_msg(EV_CODE[i], got_cnt);
		end
		quiet();
	endtask

	task t_gate;
		wr(OFF_EVENT_CHOICE, 32'(EV_CODE[3]));
		wr(OFF_NOTIFY, ZERO);
		rd_chk(OFF_NOTIFY, ZERO);
		wr(OFF_EVENT_CHOICE, 32'(EV_CODE[2]));
		rd_chk(OFF_NOTIFY, ONE);
		pulse(8'h08);
		quiet();
		wr(OFF_HOST_PORT, ZERO);
		pulse(8'h04);
		quiet();
		wr(OFF_HOST_PORT, ONE);
		quiet();
		cnt0 = got_cnt;
		pulse(8'h04);
		expect_msg(EV_CODE[2], cnt0);
	endtask

	initial begin
		do_reset(1'b1);
		t_boot(ZERO);
		t_regs();
		t_sets();
		t_events();
		t_gate();
		print_verdict();
	end
endmodule
